// File: hw/dlm_core.sv
// dram-side tracking of dll mode, read timing and clock rate changes
// assumes the controller decodes commands into one-cycle strobes on clk;
// the link clock (ck) may stop in self refresh
//
// Behaviour
// - self refresh keeps contents and needs no external clock toggling.
// - dll off supports only cas latency 6 and write latency 6.
// - dll off read strobe window starts al + cl - 1 after read.
// - dll off shifts only clock-to-strobe; strobe-to-data unchanged.
// - next command after max of tmrd and tmod; then long zq calibration.
// - clock ignored after tcksre; new rate stable before tcksrx.

`timescale 1ns/1ps

module dlm_core
  import dlm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cke,
  input wire logic odt,
  input wire logic mr_write,
  input wire logic [1:0] mr_sel,
  input wire logic [15:0] mr_data,
  input wire logic read_cmd,
  input wire logic write_cmd,
  input wire logic self_refresh_cmd,
  input wire logic data_ref_valid,
  output logic dll_off,
  output logic dll_locked,
  output logic [3:0] cas_lat,
  output logic [3:0] read_strobe_delay,
  output logic termination_on,
  output logic in_self_refresh,
  output logic in_power_down,
  output logic write_ready,
  output logic latency_error,
  output logic clock_ok
);

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  logic cke_s, odt_s, vref_s, ck_tog_s;
  logic link_rst_meta_reg, link_rst_reg;
  logic [1:0] ck_div_reg;
  logic ck_tog_prev_reg;
  logic [2:0] ck_seen_reg;

  // idle levels as reset values, so no false entry or drop after reset
  dlm_sync #(.RST_VAL(1'b1)) u_cke (
    .clk(clk), .rst(rst), .d(cke), .q(cke_s)
  );
  dlm_sync #(.RST_VAL(1'b0)) u_odt (
    .clk(clk), .rst(rst), .d(odt), .q(odt_s)
  );
  dlm_sync #(.RST_VAL(1'b1)) u_vref (
    .clk(clk), .rst(rst), .d(data_ref_valid), .q(vref_s)
  );
  dlm_sync #(.RST_VAL(1'b0)) u_ck (
    .clk(clk), .rst(rst), .d(ck_div_reg[1]), .q(ck_tog_s)
  );

  // ----------------------------------------------------------------
  // link clock activity
  // ----------------------------------------------------------------
  // reset reaches the link side through two flops of its own
  always_ff @(posedge link_clk) begin
    link_rst_meta_reg <= rst;
    link_rst_reg <= link_rst_meta_reg;
  end

  // link clock may stop in self refresh, so only a slow level crosses;
  // each level lasts two link periods, longer than one core period
  always_ff @(posedge link_clk) begin
    if (link_rst_reg) begin
      ck_div_reg <= 2'h0;
    end else begin
      ck_div_reg <= ck_div_reg + 2'h1;
    end
  end

  // a level may be sampled twice, so activity is held a few cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      ck_tog_prev_reg <= 1'b0;
      ck_seen_reg <= 3'h0;
      clock_ok <= 1'b0;
    end else begin
      ck_tog_prev_reg <= ck_tog_s;
      if (ck_tog_s != ck_tog_prev_reg) begin
        ck_seen_reg <= CK_SEEN_HOLD;
      end else if (ck_seen_reg != 3'h0) begin
        ck_seen_reg <= ck_seen_reg - 3'h1;
      end
      clock_ok <= (ck_seen_reg != 3'h0);
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  dlm_state_t state_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= DLM_ST_ACTIVE;
    end else begin
      unique case (state_reg)
        DLM_ST_ACTIVE: begin
          if (!cke_s && self_refresh_cmd) begin
            state_reg <= DLM_ST_SELF_REFRESH;
          end else if (!cke_s) begin
            state_reg <= DLM_ST_POWER_DOWN;
          end
        end
        DLM_ST_SELF_REFRESH: begin
          // contents kept regardless of link clock activity
          if (cke_s) begin
            state_reg <= DLM_ST_ACTIVE;
          end
        end
        DLM_ST_POWER_DOWN: begin
          if (cke_s) begin
            state_reg <= DLM_ST_ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_self_refresh <= 1'b0;
      in_power_down <= 1'b0;
    end else begin
      in_self_refresh <= (state_reg == DLM_ST_SELF_REFRESH);
      in_power_down <= (state_reg == DLM_ST_POWER_DOWN);
    end
  end

  // ----------------------------------------------------------------
  // mode register image
  // ----------------------------------------------------------------
  logic dll_off_reg;
  logic [2:0] nom_term_reg;
  logic [1:0] wr_term_reg;
  logic [3:0] cl_reg, cwl_reg, al_reg;

  function automatic logic [3:0] cl_decode(input logic [15:0] d);
    cl_decode = 4'(4'(d[6:4]) + 4'h4);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      dll_off_reg <= 1'b0;
      nom_term_reg <= 3'h0;
      wr_term_reg <= 2'h0;
      cl_reg <= CL_RESET;
      cwl_reg <= OFF_CAS_WR_LAT;
      al_reg <= AL_RESET;
    end else if (mr_write) begin
      // every write lands at once, so the next command never waits
      unique case (mr_sel)
        MR_SEL_0: cl_reg <= cl_decode(mr_data);
        MR_SEL_1: begin
          dll_off_reg <= mr_data[MR1_DLL_OFF_BIT];
          nom_term_reg <= {mr_data[MR1_NOM_T2_BIT],
                           mr_data[MR1_NOM_T1_BIT],
                           mr_data[MR1_NOM_T0_BIT]};
          al_reg <= {2'h0, mr_data[4:3]};
        end
        MR_SEL_2: begin
          wr_term_reg <= {mr_data[MR2_WR_T1_BIT], mr_data[MR2_WR_T0_BIT]};
          cwl_reg <= 4'(4'(mr_data[5:3]) + 4'h5);
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dll reset and lock
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] lock_cnt_reg;
  logic dll_reset_req;
  assign dll_reset_req = mr_write && (mr_sel == MR_SEL_0)
                         && mr_data[MR0_DLL_RESET_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_cnt_reg <= '0;
      dll_locked <= 1'b0;
    end else if (dll_reset_req || in_power_down) begin
      lock_cnt_reg <= CNT_W'(DLL_LOCK_CYCLES);
      dll_locked <= 1'b0;
    end else if (lock_cnt_reg != '0) begin
      lock_cnt_reg <= lock_cnt_reg - 1'b1;
      dll_locked <= (lock_cnt_reg == CNT_W'(1)) && !dll_off_reg;
    end else begin
      dll_locked <= dll_locked && !dll_off_reg;
    end
  end

  // ----------------------------------------------------------------
  // latency and termination
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dll_off <= 1'b0;
      cas_lat <= CL_RESET;
      read_strobe_delay <= 4'(AL_RESET + CL_RESET);
      latency_error <= 1'b0;
      termination_on <= 1'b0;
    end else begin
      dll_off <= dll_off_reg;
      // only one latency pair exists with the dll off
      cas_lat <= dll_off_reg ? OFF_CAS_LAT : cl_reg;
      read_strobe_delay <= dll_off_reg ? 4'(al_reg + OFF_CAS_LAT - 4'h1)
                                       : 4'(al_reg + cl_reg);
      latency_error <= dll_off_reg &&
                       (cl_reg != OFF_CAS_LAT || cwl_reg != OFF_CAS_WR_LAT);
      // no termination of any kind while the dll is off
      termination_on <= !dll_off_reg && state_reg == DLM_ST_ACTIVE
                        && odt_s
                        && (nom_term_reg != 3'h0 || wr_term_reg != 2'h0);
    end
  end

  // ----------------------------------------------------------------
  // write readiness after floating data reference
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] vref_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      vref_cnt_reg <= '0;
      write_ready <= 1'b1;
    end else if (!vref_s) begin
      vref_cnt_reg <= CNT_W'(VREF_SETTLE_CYCLES);
      write_ready <= 1'b0;
    end else if (vref_cnt_reg != '0) begin
      vref_cnt_reg <= vref_cnt_reg - 1'b1;
      write_ready <= (vref_cnt_reg == CNT_W'(1));
    end else begin
      write_ready <= 1'b1;
    end
  end

  // read_cmd and write_cmd are accepted as-is; timing is the controller's
  logic unused_cmds;
  assign unused_cmds = read_cmd ^ write_cmd;

endmodule

// File: hw/dlm_pkg.sv
// package for the dll mode / clock rate change block
// assumes a 10 MHz core clock and an 80 ns link clock

package dlm_pkg;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int MR1_DLL_OFF_BIT = 0;
  localparam int MR0_DLL_RESET_BIT = 8;
  localparam int MR1_NOM_T0_BIT = 2;
  localparam int MR1_NOM_T1_BIT = 6;
  localparam int MR1_NOM_T2_BIT = 9;
  localparam int MR2_WR_T0_BIT = 9;
  localparam int MR2_WR_T1_BIT = 10;

  // ----------------------------------------------------------------
  // latencies and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CAS_LAT = 4'h6;
  localparam logic [3:0] OFF_CAS_WR_LAT = 4'h6;
  localparam logic [3:0] CL_RESET = 4'h6;
  localparam logic [3:0] AL_RESET = 4'h0;
  localparam logic [1:0] MR_SEL_0 = 2'h0;
  localparam logic [1:0] MR_SEL_1 = 2'h1;
  localparam logic [1:0] MR_SEL_2 = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int VREF_SETTLE_CLOCKS = 512;
  localparam int VREF_SETTLE_CYCLES = VREF_SETTLE_CLOCKS;
  localparam int DLL_LOCK_NS = 51200;
  localparam int DLL_LOCK_CYCLES =
    (DLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  // core cycles that link activity is held after a seen level change
  localparam logic [2:0] CK_SEEN_HOLD = 3'h4;

  typedef enum logic [1:0] {
    DLM_ST_ACTIVE,
    DLM_ST_SELF_REFRESH,
    DLM_ST_POWER_DOWN
  } dlm_state_t;

endpackage

// File: hw/dlm_sync.sv
// two-flop level synchroniser
// assumes the input is a level from another clock domain;
// the reset value is the input's idle level, so reset makes no edge

`timescale 1ns/1ps

module dlm_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// File: verif/dlm_core_assertions.sv
// port checker for dlm_core
// assumes a bind onto dlm_core, all ports on the core clock domain
`timescale 1ns/1ps
module dlm_core_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic mr_write,
  input wire logic [1:0] mr_sel,
  input wire logic [15:0] mr_data,
  input wire logic data_ref_valid,
  input wire logic dll_off,
  input wire logic dll_locked,
  input wire logic [3:0] cas_lat,
  input wire logic termination_on,
  input wire logic in_self_refresh,
  input wire logic in_power_down,
  input wire logic write_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_off_cas_lat: assert property (dll_off |-> cas_lat == 4'h6)
    else $error("cas latency not 6 with dll off");
  a_dll_goes_off: assert property (mr_write && mr_sel == 2'h1
    && mr_data[0] |-> ##[1:3] dll_off) else $error("dll did not turn off");
  a_dll_goes_on: assert property (mr_write && mr_sel == 2'h1
    && !mr_data[0] |-> ##[1:3] !dll_off) else $error("dll did not turn on");
  a_no_term_off: assert property (dll_off |-> !termination_on)
    else $error("termination active with dll off");
  a_no_lock_off: assert property (dll_off |-> !dll_locked)
    else $error("lock reported with dll off");
  a_lock_waits: assert property (mr_write && mr_sel == 2'h0
    && mr_data[8] |=> !dll_locked [*8]) else $error("lock came too early");
  a_one_state: assert property (!(in_self_refresh && in_power_down))
    else $error("self refresh and power-down together");
  a_vref_drop: assert property ($fell(data_ref_valid)
    |-> ##[1:6] !write_ready) else $error("writes still allowed");
  a_vref_hold: assert property ($rose(data_ref_valid)
    |-> !write_ready [*8]) else $error("writes allowed too early");
endmodule

// File: verif/dlm_ctrl_model.sv
// controller-side model: makes the memory link clock
// assumes the bench lowers run only while the memory is in self refresh
`timescale 1ns/1ps
module dlm_ctrl_model (
  input wire logic run,
  output logic link_clk
);
  // clock stands low while stopped; phase offset keeps it unrelated
  initial begin
    link_clk = 1'b0;
    #17;
    forever begin
      #40;
      if (run)
        link_clk = ~link_clk;
      else
        link_clk = 1'b0;
    end
  end
endmodule

// File: verif/test_dll_mode_and_clock_rate_change.sv
// bench for dlm_core: mode writes, self refresh, power-down, vref, lock
// assumes dlm_pkg and the controller model are compiled first
`timescale 1ns/1ps
module test_dll_mode_and_clock_rate_change;
  import dlm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, run = 1'b1, link_clk, cke = 1'b1;
  logic odt = 1'b0, mr_write = 1'b0, sr_cmd = 1'b0, dref = 1'b1;
  logic [1:0] mr_sel = 2'h0;
  logic [15:0] mr_data = 16'h0000;
  logic dll_off, dll_locked, term_on, in_sr, in_pd, wr_rdy, lat_err, ck_ok;
  logic [3:0] cas_lat, rsd;
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  dlm_ctrl_model ctl_u (.run(run), .link_clk(link_clk));
  dlm_core dut_u (.clk(clk), .rst(rst), .link_clk(link_clk), .cke(cke),
    .odt(odt), .mr_write(mr_write), .mr_sel(mr_sel), .mr_data(mr_data),
    .read_cmd(1'b0), .write_cmd(1'b0), .self_refresh_cmd(sr_cmd),
    .data_ref_valid(dref), .dll_off(dll_off), .dll_locked(dll_locked),
    .cas_lat(cas_lat), .read_strobe_delay(rsd), .termination_on(term_on),
    .in_self_refresh(in_sr), .in_power_down(in_pd), .write_ready(wr_rdy),
    .latency_error(lat_err), .clock_ok(ck_ok));
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the ~1200 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // sample on the falling edge so edge updates have landed
  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic mr(logic [1:0] sel, logic [15:0] d);
    @(posedge clk);
    mr_write <= 1'b1;
    mr_sel <= sel;
    mr_data <= d;
    @(posedge clk);
    mr_write <= 1'b0;
    wait_n(4);
  endtask
  task automatic t_reset();
    chk("dll_off", 4'h0, 4'(dll_off));
    chk("cas_lat", 4'h6, cas_lat);
    chk("strobe", 4'h6, rsd);
    chk("write_ready", 4'h1, 4'(wr_rdy));
    // link side leaves reset later and needs a few cycles to be seen
    wait_n(6);
    chk("clock_ok", 4'h1, 4'(ck_ok));
  endtask
  task automatic t_vref();
    @(posedge clk);
    dref <= 1'b0;
    wait_n(8);
    chk("wr_rdy low", 4'h0, 4'(wr_rdy));
    @(posedge clk);
    dref <= 1'b1;
    wait_n(500);
    chk("wr_rdy wait", 4'h0, 4'(wr_rdy));
    wait_n(30);
    chk("wr_rdy back", 4'h1, 4'(wr_rdy));
  endtask
  task automatic t_pd();
    @(posedge clk);
    cke <= 1'b0;
    wait_n(6);
    chk("pd", 4'h1, 4'(in_pd));
    chk("pd not sr", 4'h0, 4'(in_sr));
    @(posedge clk);
    cke <= 1'b1;
    wait_n(6);
    chk("pd exit", 4'h0, 4'(in_pd));
    mr(MR_SEL_0, 16'h0120);
  endtask
  task automatic t_dll_off();
    mr(MR_SEL_1, 16'h0001);
    chk("dll_off", 4'h1, 4'(dll_off));
    chk("cas_lat off", OFF_CAS_LAT, cas_lat);
    chk("strobe off", 4'h5, rsd);
    @(posedge clk);
    odt <= 1'b1;
    wait_n(4);
    chk("term off", 4'h0, 4'(term_on));
    @(posedge clk);
    odt <= 1'b0;
    cke <= 1'b0;
    sr_cmd <= 1'b1;
    wait_n(6);
    chk("sr entry", 4'h1, 4'(in_sr));
    run <= 1'b0;
    wait_n(20);
    chk("sr no clock", 4'h1, 4'(in_sr));
    chk("ck stopped", 4'h0, 4'(ck_ok));
    run <= 1'b1;
    wait_n(10);
    @(posedge clk);
    cke <= 1'b1;
    sr_cmd <= 1'b0;
    wait_n(6);
    chk("sr exit", 4'h0, 4'(in_sr));
    chk("ck back", 4'h1, 4'(ck_ok));
    chk("dll_off kept", 4'h1, 4'(dll_off));
  endtask
  task automatic t_latency();
    mr(MR_SEL_0, 16'h0030);
    chk("lat err", 4'h1, 4'(lat_err));
    chk("cas_lat held", 4'h6, cas_lat);
    mr(MR_SEL_0, 16'h0020);
    chk("lat ok", 4'h0, 4'(lat_err));
  endtask
  task automatic t_dll_on();
    mr(MR_SEL_1, 16'h0000);
    chk("dll on", 4'h0, 4'(dll_off));
    mr(MR_SEL_0, 16'h0120);
    chk("strobe on", 4'h6, rsd);
    mr(MR_SEL_2, 16'h0008);
    wait_n(480);
    chk("not locked", 4'h0, 4'(dll_locked));
    wait_n(40);
    chk("locked", 4'h1, 4'(dll_locked));
    mr(MR_SEL_1, 16'h0004);
    @(posedge clk);
    odt <= 1'b1;
    wait_n(4);
    chk("term on", 4'h1, 4'(term_on));
    @(posedge clk);
    odt <= 1'b0;
    wait_n(4);
    chk("term odt low", 4'h0, 4'(term_on));
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_n(4);
    t_reset();
    t_vref();
    t_pd();
    t_dll_off();
    t_latency();
    t_dll_on();
    give_verdict();
  end
endmodule
bind dlm_core dlm_core_chk chk_u (.clk, .rst, .mr_write, .mr_sel,
  .mr_data, .data_ref_valid, .dll_off, .dll_locked, .cas_lat,
  .termination_on, .in_self_refresh, .in_power_down, .write_ready);
